// ==== dv/ttoc_partner.sv ====
`timescale 1ns/1ns
// slave timer and dma controller counting what the master sends
module ttoc_partner #(parameter CHANNELS = 4) (
    input  logic                mclk,
    input  logic                reset,
    input  logic                trigger_output,
    input  logic [CHANNELS-1:0] channel_dma_request,
    output int                  slave_ticks,
    output int                  dma_grants
);
    logic last;
    // prescaler ticks on a rising trigger, dma serves every request
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            last <= 0;
            slave_ticks <= 0;
            dma_grants <= 0;
        end else begin
            last <= trigger_output;
            slave_ticks <= slave_ticks + (trigger_output && !last);
            dma_grants <= dma_grants + $countones(channel_dma_request);
        end
    end
endmodule // ttoc_partner

// ==== dv/ttoc_tb_top.sv ====
`timescale 1ns/1ns
`include "ttoc_defs.vh"
module timer_trigger_output_control_tb_top;
    logic mclk = 0, reset = 1, reg_write = 0, reg_read = 0, channel_one_pin = 0, channel_two_pin = 0, e;
    logic channel_three_pin = 0, external_trigger_input = 0, counter_enable_bit = 0, trigger_input = 0, gated_mode = 0;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, r;
    logic [11:0] st = 0;
    logic [3:0] channel_dma_request;
    logic [2:0] master_trigger_source_select;
    logic first_timer_input, external_trigger_conditioned, trigger_output, counter_enable_signal, trigger_input_event;
    logic first_input_xor_select, channel_dma_timing_select;
    wire [3:0] channel_event;
    wire update_generate_command, slave_reset_event, update_event, channel_one_capture_compare;
    wire compare_reference_one, compare_reference_two, compare_reference_three, compare_reference_four;
    int fails = 0, tests_run = 0, cyc = 0, slave_ticks, dma_grants, i, n, ce, te, t0, d0;
    integer seed = 32'h4ce1;
    // random event and reference stimulus fans out to the inputs
    assign {update_generate_command, slave_reset_event, update_event, channel_one_capture_compare, compare_reference_one,
            compare_reference_two, compare_reference_three, compare_reference_four, channel_event} = st;
    ttoc_top #(.CHANNELS(4)) u_ttoc_top (.*);
    ttoc_partner #(.CHANNELS(4)) u_ttoc_partner (.*);
    always #2 mclk = ~mclk;
    // cut a hung run short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            wrap_up;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] x, input string m);
        tests_run++;
        if (got !== x) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1;
        @(posedge mclk);
        reg_write <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1;
        @(posedge mclk);
        reg_read <= 0;
        #1 chk(reg_rdata, x, "read");
    endtask
    task automatic wrap_up;
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 0;
        rd(8'h04, `TTOC_CTRL2_RESET);
        rd(8'h08, `TTOC_SLAVE_CTRL_RESET);
        chk(master_trigger_source_select, 0, "reset select");
        repeat (4) begin
            r = $random(seed);
            wr(8'h04, r);
            wr(8'h08, r);
            wr(8'h0c, r);
            rd(8'h04, r & `TTOC_CTRL2_MASK);
            rd(8'h08, r & `TTOC_SLAVE_CTRL_MASK);
            rd(8'h0c, 0);
        end
        wr(8'h08, 0);
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            wr(8'h04, {i[2:0], i[0], 3'h0});
            repeat (3) @(posedge mclk);
            repeat (12) begin
                r = $random(seed);
                st <= r[11:0];
                case (i[2:0])
                    0: e = r[11] | r[10];
                    1: e = 0;
                    2: e = r[9];
                    3: e = r[8];
                    default: e = r[7 - i[1:0]];
                endcase
                @(posedge mclk);
                #1 chk(trigger_output, e, "trigger");
                chk(channel_dma_request, i[0] ? {4{r[9]}} : r[3:0], "dma");
                @(posedge mclk);
            end
            chk(master_trigger_source_select, i[2:0], "select field");
            chk(channel_dma_timing_select, i[0], "dma select field");
        end
        st <= 0;
        $display("test trigger sources done");
        for (i = 0; i < 12; i++) begin
            r = $random(seed);
            wr(8'h04, {24'h0, i[0], 7'h0});
            wr(8'h08, {16'h0, i[0], 15'h0});
            {channel_one_pin, channel_two_pin, channel_three_pin, external_trigger_input} <= r[3:0];
            repeat (5) @(posedge mclk);
            #1 chk(first_timer_input, i[0] ? ^r[3:1] : r[3], "first input");
            chk(external_trigger_conditioned, r[0] ^ i[0], "ext trigger");
            chk(first_input_xor_select, i[0], "xor select field");
        end
        $display("test inputs done");
        for (i = 0; i < 2; i++) begin
            wr(8'h08, {24'h0, i[0], 7'h0});
            wr(8'h04, 32'h10);
            repeat (3) @(posedge mclk);
            gated_mode <= 1;
            trigger_input <= 1;
            ce = 0;
            te = 0;
            for (n = 1; n < 5; n++) begin
                @(posedge mclk);
                #1 if (counter_enable_signal === 1 && ce == 0) ce = n;
                if (trigger_input_event === 1 && te == 0) te = n;
            end
            chk(ce, i ? 1 : 2, "enable delay");
            chk(te, i ? 2 : 1, "trigger delay");
            chk(trigger_output, 1, "enable trigger");
            @(posedge mclk);
            gated_mode <= 0;
            trigger_input <= 0;
            counter_enable_bit <= i[0];
            repeat (3) @(posedge mclk);
        end
        #1 chk(counter_enable_signal, 1, "enable bit");
        @(posedge mclk);
        counter_enable_bit <= 0;
        $display("test enable done");
        wr(8'h04, 32'h28);
        repeat (3) @(posedge mclk);
        t0 = slave_ticks;
        d0 = dma_grants;
        repeat (5) begin
            @(posedge mclk);
            st <= 12'h200;
            @(posedge mclk);
            st <= 0;
        end
        repeat (3) @(posedge mclk);
        chk(slave_ticks - t0, 5, "slave count");
        chk(dma_grants - d0, 20, "dma count");
        $display("test partner done");
        wrap_up;
    end
endmodule // timer_trigger_output_control_tb_top

// ==== dv/ttoc_top_properties.sv ====
`timescale 1ns/1ns
// routing checks at the block ports
module ttoc_checker #(parameter CHANNELS = 4) (
    input logic                mclk, reset, channel_one_pin, channel_two_pin, channel_three_pin,
    input logic                update_generate_command, slave_reset_event, update_event, channel_one_capture_compare,
    input logic                compare_reference_one, compare_reference_two, compare_reference_three,
    input logic                compare_reference_four, trigger_input, trigger_input_event, trigger_output,
    input logic                first_timer_input, first_input_xor_select, channel_dma_timing_select,
    input logic [CHANNELS-1:0] channel_event, channel_dma_request,
    input logic [2:0]          master_trigger_source_select
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // short aliases
    wire [2:0] mm = master_trigger_source_select;
    wire [3:0] refs = {compare_reference_four, compare_reference_three, compare_reference_two, compare_reference_one};
    wire       x3 = channel_one_pin ^ channel_two_pin ^ channel_three_pin;
    sequence s_sel_held; $stable(first_input_xor_select) [*4]; endsequence
    property p_rst; $past(reset) |-> mm == 3'h0 && !trigger_output; endproperty
    a_rst: assert property (p_rst) else $error("select not clear");
    property p_ug; mm == 3'h0 && $stable(mm) |-> trigger_output == $past(update_generate_command | slave_reset_event);
    endproperty
    a_ug: assert property (p_ug) else $error("code 0 trigger");
    property p_upd; mm == 3'h2 && $stable(mm) |-> trigger_output == $past(update_event); endproperty
    a_upd: assert property (p_upd) else $error("code 2 trigger");
    property p_cc1; mm == 3'h3 && $past(mm) == 3'h3 && $past(channel_one_capture_compare) |-> trigger_output;
    endproperty
    a_cc1: assert property (p_cc1) else $error("code 3 pulse");
    property p_ref; mm[2] && $stable(mm) |-> trigger_output == $past(refs[mm[1:0]]); endproperty
    a_ref: assert property (p_ref) else $error("reference trigger");
    property p_dma; $stable(channel_dma_timing_select) |-> channel_dma_request ==
        (channel_dma_timing_select ? {CHANNELS{$past(update_event)}} : $past(channel_event)); endproperty
    a_dma: assert property (p_dma) else $error("dma request");
    property p_ti1; s_sel_held |->
        first_timer_input == (first_input_xor_select ? $past(x3, 3) : $past(channel_one_pin, 3)); endproperty
    a_ti1: assert property (p_ti1) else $error("first input");
    property p_tie; !trigger_input [*2] |=> !trigger_input_event; endproperty
    a_tie: assert property (p_tie) else $error("trigger event");
    c_pulse: cover property (mm == 3'h3 && trigger_output);
    c_dma: cover property (channel_dma_timing_select && channel_dma_request != 0);
    c_xor: cover property (first_input_xor_select && first_timer_input);
endmodule // ttoc_checker
bind ttoc_top ttoc_checker #(.CHANNELS(CHANNELS)) u_ttoc_checker (.*);

// ==== rtl/ttoc_defs.vh ====
`ifndef TTOC_DEFS_VH
`define TTOC_DEFS_VH
// register byte offsets
`define TTOC_ADDR_CTRL2        8'h04
`define TTOC_ADDR_SLAVE_CTRL   8'h08
// control two field positions
`define TTOC_XOR_SEL_BIT       7
`define TTOC_SRC_LSB           4
`define TTOC_SRC_MSB           6
`define TTOC_DMA_SEL_BIT       3
// slave mode control field positions
`define TTOC_EXT_POL_BIT       15
`define TTOC_EXT_CLK2_BIT      14
`define TTOC_SYNC_BIT          7
// writable bit masks
`define TTOC_CTRL2_MASK        32'h000000f8
`define TTOC_SLAVE_CTRL_MASK   32'h0000ffff
// reset values
`define TTOC_CTRL2_RESET       32'h00000000
`define TTOC_SLAVE_CTRL_RESET  32'h00000000
// master mode codes
`define TTOC_MM_RESET          3'h0
`define TTOC_MM_ENABLE         3'h1
`define TTOC_MM_UPDATE         3'h2
`define TTOC_MM_CMP_PULSE      3'h3
`define TTOC_MM_OC1            3'h4
`define TTOC_MM_OC2            3'h5
`define TTOC_MM_OC3            3'h6
`define TTOC_MM_OC4            3'h7
`endif

// ==== rtl/ttoc_sync2.v ====
`timescale 1ns/1ns
// two flop synchroniser, one per bit
module ttoc_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             mclk,
    input  wire             reset,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage_one;

    // first stage feeds only the second
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            stage_one <= {WIDTH{1'b0}};
            sync_out  <= {WIDTH{1'b0}};
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule // ttoc_sync2

// ==== rtl/ttoc_top.v ====
`timescale 1ns/1ns
`include "ttoc_defs.vh"
module ttoc_top #(
    parameter CHANNELS = 4
) (
    input  wire                mclk,
    input  wire                reset,
    input  wire [7:0]          reg_addr,
    input  wire [31:0]         reg_wdata,
    input  wire                reg_write,
    input  wire                reg_read,
    output reg  [31:0]         reg_rdata,
    input  wire                channel_one_pin,
    input  wire                channel_two_pin,
    input  wire                channel_three_pin,
    input  wire                external_trigger_input,
    input  wire                update_generate_command,
    input  wire                slave_reset_event,
    input  wire                counter_enable_bit,
    input  wire                trigger_input,
    input  wire                gated_mode,
    input  wire                update_event,
    input  wire                channel_one_capture_compare,
    input  wire [CHANNELS-1:0] channel_event,
    input  wire                compare_reference_one,
    input  wire                compare_reference_two,
    input  wire                compare_reference_three,
    input  wire                compare_reference_four,
    output reg                 first_timer_input,
    output reg                 external_trigger_conditioned,
    output reg                 trigger_output,
    output reg                 counter_enable_signal,
    output reg                 trigger_input_event,
    output reg  [CHANNELS-1:0] channel_dma_request,
    output reg                 first_input_xor_select,
    output reg  [2:0]          master_trigger_source_select,
    output reg                 channel_dma_timing_select
);
    // positions within the compare reference vector
    localparam REF_ONE   = 0;
    localparam REF_TWO   = 1;
    localparam REF_THREE = 2;
    localparam REF_FOUR  = 3;

    reg  [31:0]         timer_control_two;
    reg  [31:0]         timer_slave_mode_control;
    wire [3:0]          pins_sync;
    wire                write_control_two;
    wire                write_slave_control;
    wire                external_trigger_polarity;
    wire                master_slave_sync_bit;
    wire [2:0]          master_source_code;
    wire                gated_term;
    wire                first_input_xor;
    wire                dma_on_update;
    wire [3:0]          reference_vector;
    reg                 gated_delayed;
    reg                 trigger_input_delayed;
    reg                 next_trigger_output;
    reg                 next_enable;
    reg                 next_first_input;
    reg                 next_external_trigger;
    reg                 next_trigger_event;
    reg  [CHANNELS-1:0] next_dma;
    reg  [31:0]         next_rdata;

    // pin inputs pass two flops before use
    ttoc_sync2 #(
        .WIDTH (4)
    ) u_pin_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in ({external_trigger_input, channel_three_pin, channel_two_pin, channel_one_pin}),
        .sync_out (pins_sync)
    );

    // address decode and write qualifiers
    assign write_control_two   = reg_write & (reg_addr == `TTOC_ADDR_CTRL2);
    assign write_slave_control = reg_write & (reg_addr == `TTOC_ADDR_SLAVE_CTRL);

    // live register fields used by the datapath
    assign external_trigger_polarity = timer_slave_mode_control[`TTOC_EXT_POL_BIT];
    assign master_slave_sync_bit     = timer_slave_mode_control[`TTOC_SYNC_BIT];
    assign master_source_code        = timer_control_two[`TTOC_SRC_MSB:`TTOC_SRC_LSB];
    assign dma_on_update             = timer_control_two[`TTOC_DMA_SEL_BIT];

    // gated mode term of the counter enable
    assign gated_term = gated_mode & trigger_input;

    // xor of the three synchronised channel pins
    assign first_input_xor = pins_sync[0] ^ pins_sync[1] ^ pins_sync[2];

    // compare references, channel one in bit zero
    assign reference_vector = {compare_reference_four, compare_reference_three,
                               compare_reference_two, compare_reference_one};

    // control two register, reserved bits masked off
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            timer_control_two <= `TTOC_CTRL2_RESET;
        end else if (write_control_two) begin
            timer_control_two <= reg_wdata & `TTOC_CTRL2_MASK;
        end
    end

    // slave mode control register, upper half reserved
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            timer_slave_mode_control <= `TTOC_SLAVE_CTRL_RESET;
        end else if (write_slave_control) begin
            timer_slave_mode_control <= reg_wdata & `TTOC_SLAVE_CTRL_MASK;
        end
    end

    // read data select, unmapped reads zero
    always @* begin
        next_rdata = 32'h00000000;
        if (reg_read) begin
            case (reg_addr)
                `TTOC_ADDR_CTRL2: begin
                    next_rdata = timer_control_two;
                end
                `TTOC_ADDR_SLAVE_CTRL: begin
                    next_rdata = timer_slave_mode_control;
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    // read data register, valid the cycle after the strobe
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // copy of the input selection bit
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            first_input_xor_select <= 1'b0;
        end else begin
            first_input_xor_select <= timer_control_two[`TTOC_XOR_SEL_BIT];
        end
    end

    // copy of the master mode field
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            master_trigger_source_select <= `TTOC_MM_RESET;
        end else begin
            master_trigger_source_select <= master_source_code;
        end
    end

    // copy of the dma timing bit
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            channel_dma_timing_select <= 1'b0;
        end else begin
            channel_dma_timing_select <= dma_on_update;
        end
    end

    // first timer input source: one pin or xor of three
    always @* begin
        if (timer_control_two[`TTOC_XOR_SEL_BIT]) begin
            next_first_input = first_input_xor;
        end else begin
            next_first_input = pins_sync[0];
        end
    end

    // external trigger polarity
    always @* begin
        if (external_trigger_polarity) begin
            next_external_trigger = ~pins_sync[3];
        end else begin
            next_external_trigger = pins_sync[3];
        end
    end

    // first timer input register
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            first_timer_input <= 1'b0;
        end else begin
            first_timer_input <= next_first_input;
        end
    end

    // conditioned external trigger register
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            external_trigger_conditioned <= 1'b0;
        end else begin
            external_trigger_conditioned <= next_external_trigger;
        end
    end

    // gated term one cycle late, the unsynchronised path
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            gated_delayed <= 1'b0;
        end else begin
            gated_delayed <= gated_term;
        end
    end

    // trigger input one cycle late, the sync path
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            trigger_input_delayed <= 1'b0;
        end else begin
            trigger_input_delayed <= trigger_input;
        end
    end

    // counter enable: sync mode uses the undelayed gated term
    always @* begin
        if (master_slave_sync_bit) begin
            next_enable = counter_enable_bit | gated_term;
        end else begin
            next_enable = counter_enable_bit | gated_delayed;
        end
    end

    // trigger output source select
    always @* begin
        case (master_source_code)
            `TTOC_MM_RESET: begin
                next_trigger_output = update_generate_command | slave_reset_event;
            end
            `TTOC_MM_ENABLE: begin
                next_trigger_output = next_enable;
            end
            `TTOC_MM_UPDATE: begin
                next_trigger_output = update_event;
            end
            `TTOC_MM_CMP_PULSE: begin
                next_trigger_output = channel_one_capture_compare;
            end
            `TTOC_MM_OC1: begin
                next_trigger_output = reference_vector[REF_ONE];
            end
            `TTOC_MM_OC2: begin
                next_trigger_output = reference_vector[REF_TWO];
            end
            `TTOC_MM_OC3: begin
                next_trigger_output = reference_vector[REF_THREE];
            end
            `TTOC_MM_OC4: begin
                next_trigger_output = reference_vector[REF_FOUR];
            end
            default: begin
                next_trigger_output = 1'b0;
            end
        endcase
    end

    // sync mode holds trigger input events back one cycle
    always @* begin
        if (master_slave_sync_bit) begin
            next_trigger_event = trigger_input_delayed;
        end else begin
            next_trigger_event = trigger_input;
        end
    end

    // trigger output register toward slave timers
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            trigger_output <= 1'b0;
        end else begin
            trigger_output <= next_trigger_output;
        end
    end

    // counter enable register
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            counter_enable_signal <= 1'b0;
        end else begin
            counter_enable_signal <= next_enable;
        end
    end

    // trigger input event register
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            trigger_input_event <= 1'b0;
        end else begin
            trigger_input_event <= next_trigger_event;
        end
    end

    // per channel dma request timing
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_dma
            // request source per channel
            always @* begin
                if (dma_on_update) begin
                    next_dma[ch] = update_event;
                end else begin
                    next_dma[ch] = channel_event[ch];
                end
            end

            // request register per channel
            always @(posedge mclk or posedge reset) begin
                if (reset) begin
                    channel_dma_request[ch] <= 1'b0;
                end else begin
                    channel_dma_request[ch] <= next_dma[ch];
                end
            end
        end
    endgenerate
endmodule // ttoc_top
